//--- logic/ext_bus_pkg.sv
// Constants and types for the external bus strobe and hold controller.
// Assumes a single 100 MHz system clock and a synchronous active-low reset.
package ext_bus_pkg;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int CLK_HZ = 100_000_000;
	// Bus clock frequency and derived divider
	localparam int BCLK_HZ = 25_000_000;
	localparam int BCLK_DIV = (CLK_HZ + 2 * BCLK_HZ - 1) / (2 * BCLK_HZ);
	localparam logic MODE_SPLIT = 1'b0;
	localparam logic MODE_SINGLE = 1'b1;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_ADDR = 5'b00010,
		ST_STRB = 5'b00100,
		ST_DONE = 5'b01000,
		ST_HOLD = 5'b10000
	} bus_state_e;
endpackage : ext_bus_pkg

//--- logic/sync_two_ff.sv
// Two flip-flop synchroniser for asynchronous pin inputs.
// Assumes the pin is a level; no logic reads the first stage.
`timescale 1ns/10ps
module sync_two_ff #(
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic pinIn,
	output logic syncOut
);
	logic stage1;

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			stage1 <= RESET_VAL;
			syncOut <= RESET_VAL;
		end else begin
			stage1 <= pinIn;
			syncOut <= stage1;
		end
	end
endmodule : sync_two_ff

//--- logic/ext_bus_ctrl.sv
// External bus strobe, wait and hold controller.
// Assumes a core request port on clk_sys; bus request and wait come from pins.
`timescale 1ns/10ps
module ext_bus_ctrl #(
	parameter int ADDR_W = ext_bus_pkg::ADDR_W,
	parameter int DATA_W = ext_bus_pkg::DATA_W
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic strobeMode,
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic [ADDR_W-1:0] reqAddr,
	input wire logic [DATA_W-1:0] reqWdata,
	input wire logic reqWide,
	output logic reqReady,
	output logic rspValid,
	output logic [DATA_W-1:0] rspRdata,
	output logic [ADDR_W-1:0] busAddr,
	output logic busAddrOe,
	input wire logic [DATA_W-1:0] busDataIn,
	output logic [DATA_W-1:0] busDataOut,
	output logic busDataOe,
	output logic lowerLaneStoreStrobe_n,
	output logic upperLaneStoreStrobe_n,
	output logic readStrobe_n,
	output logic strobeOe,
	output logic addrLatch,
	output logic busClock,
	input wire logic waitRequest_n,
	input wire logic busRequest_n,
	output logic busGrantOutput_n
);
	ext_bus_pkg::bus_state_e state;
	ext_bus_pkg::bus_state_e next_state;
	logic holdReq_n;
	logic waitReq_n;
	logic curWrite;
	logic curWide;
	logic curOdd;
	logic [7:0] divCount;
	logic busTick;
	logic strobeOn;

	// ==========================================
	// Pin synchronisers
	sync_two_ff #(.RESET_VAL(1'b1)) holdSync (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.pinIn(busRequest_n),
		.syncOut(holdReq_n)
	);
	sync_two_ff #(.RESET_VAL(1'b1)) waitSync (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.pinIn(waitRequest_n),
		.syncOut(waitReq_n)
	);

	// ==========================================
	// Bus clock divider; each half period is one tick
	assign busTick = (divCount == 8'(ext_bus_pkg::BCLK_DIV - 1));

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			divCount <= 8'h00;
			busClock <= 1'b0;
		end else if (busTick) begin
			divCount <= 8'h00;
			busClock <= ~busClock;
		end else begin
			divCount <= divCount + 8'h01;
		end
	end

	// ==========================================
	// Access sequencer: address phase, strobe phase, done
	always_comb begin
		next_state = state;
		case (state)
			ext_bus_pkg::ST_IDLE: begin
				if (!holdReq_n)
					next_state = ext_bus_pkg::ST_HOLD;
				else if (reqValid)
					next_state = ext_bus_pkg::ST_ADDR;
			end
			ext_bus_pkg::ST_ADDR: begin
				if (busTick)
					next_state = ext_bus_pkg::ST_STRB;
			end
			ext_bus_pkg::ST_STRB: begin
				if (busTick && waitReq_n)
					next_state = ext_bus_pkg::ST_DONE;
			end
			ext_bus_pkg::ST_DONE: next_state = ext_bus_pkg::ST_IDLE;
			ext_bus_pkg::ST_HOLD: begin
				if (holdReq_n)
					next_state = ext_bus_pkg::ST_IDLE;
			end
			default: next_state = ext_bus_pkg::ST_IDLE;
		endcase
	end

	assign strobeOn = (next_state == ext_bus_pkg::ST_STRB);

	always_ff @(posedge clk_sys) begin
		if (!reset_n)
			state <= ext_bus_pkg::ST_IDLE;
		else
			state <= next_state;
	end

	// ==========================================
	// Latched request and pins
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			curWrite <= 1'b0;
			curWide <= 1'b0;
			curOdd <= 1'b0;
			busAddr <= '0;
			busDataOut <= '0;
		end else if (state == ext_bus_pkg::ST_IDLE && reqValid && holdReq_n) begin
			curWrite <= reqWrite;
			curWide <= reqWide;
			curOdd <= reqAddr[0];
			busAddr <= reqAddr;
			busDataOut <= reqWdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			lowerLaneStoreStrobe_n <= 1'b1;
			upperLaneStoreStrobe_n <= 1'b1;
			readStrobe_n <= 1'b1;
			addrLatch <= 1'b0;
			busGrantOutput_n <= 1'b1;
			busAddrOe <= 1'b1;
			busDataOe <= 1'b0;
			strobeOe <= 1'b1;
			reqReady <= 1'b0;
			rspValid <= 1'b0;
			rspRdata <= '0;
		end else begin
			busGrantOutput_n <= (next_state != ext_bus_pkg::ST_HOLD);
			busAddrOe <= (next_state != ext_bus_pkg::ST_HOLD);
			strobeOe <= (next_state != ext_bus_pkg::ST_HOLD);
			busDataOe <= curWrite && (next_state == ext_bus_pkg::ST_STRB ||
				next_state == ext_bus_pkg::ST_ADDR);
			addrLatch <= (next_state == ext_bus_pkg::ST_ADDR);
			readStrobe_n <= !(strobeOn && !curWrite);
			if (strobeMode == ext_bus_pkg::MODE_SPLIT) begin
				lowerLaneStoreStrobe_n <= !(strobeOn && curWrite &&
					(!curOdd || curWide));
				upperLaneStoreStrobe_n <= !(strobeOn && curWrite &&
					(curOdd || curWide));
			end else begin
				lowerLaneStoreStrobe_n <= !(strobeOn && curWrite);
				upperLaneStoreStrobe_n <= !(strobeOn &&
					(curOdd || curWide));
			end
			reqReady <= (state == ext_bus_pkg::ST_IDLE && reqValid && holdReq_n);
			rspValid <= (state == ext_bus_pkg::ST_STRB &&
				next_state == ext_bus_pkg::ST_DONE);
			if (state == ext_bus_pkg::ST_STRB && next_state == ext_bus_pkg::ST_DONE &&
				!curWrite)
				rspRdata <= busDataIn;
		end
	end

	// ==========================================
	// Checks
	grant_in_hold_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(state == ext_bus_pkg::ST_HOLD) |-> !busGrantOutput_n)
		else $error("grant not low in hold");
	grant_out_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(state == ext_bus_pkg::ST_IDLE) |-> busGrantOutput_n)
		else $error("grant low outside hold");
	hold_entry_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(state == ext_bus_pkg::ST_IDLE && !holdReq_n) |=> !busGrantOutput_n)
		else $error("hold not entered");
	hold_release_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(state == ext_bus_pkg::ST_HOLD) |-> (!busAddrOe && !strobeOe))
		else $error("bus driven in hold");
	data_release_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(state == ext_bus_pkg::ST_HOLD) |-> !busDataOe)
		else $error("data driven in hold");
	wait_stretch_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(state == ext_bus_pkg::ST_STRB && !waitReq_n) |=>
		(state == ext_bus_pkg::ST_STRB))
		else $error("access ended during wait");
	read_strobe_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(state == ext_bus_pkg::ST_STRB && !curWrite) |-> !readStrobe_n)
		else $error("read strobe not low");
	write_no_read_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(state == ext_bus_pkg::ST_STRB && curWrite) |-> readStrobe_n)
		else $error("read strobe low on write");
	idle_strobes_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(state == ext_bus_pkg::ST_IDLE) |->
		(readStrobe_n && lowerLaneStoreStrobe_n && upperLaneStoreStrobe_n))
		else $error("strobe active when idle");
	split_even_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(state == ext_bus_pkg::ST_STRB && curWrite && !curOdd && !curWide &&
		strobeMode == ext_bus_pkg::MODE_SPLIT && $stable(strobeMode)) |->
		(!lowerLaneStoreStrobe_n && upperLaneStoreStrobe_n))
		else $error("even write strobes wrong");
	split_wide_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(state == ext_bus_pkg::ST_STRB && curWrite && curWide &&
		strobeMode == ext_bus_pkg::MODE_SPLIT && $stable(strobeMode)) |->
		(!lowerLaneStoreStrobe_n && !upperLaneStoreStrobe_n))
		else $error("wide write strobes wrong");
	split_odd_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(state == ext_bus_pkg::ST_STRB && curWrite && curOdd && !curWide &&
		strobeMode == ext_bus_pkg::MODE_SPLIT && $stable(strobeMode)) |->
		(lowerLaneStoreStrobe_n && !upperLaneStoreStrobe_n))
		else $error("odd write strobes wrong");
	single_odd_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(state == ext_bus_pkg::ST_STRB && curOdd &&
		strobeMode == ext_bus_pkg::MODE_SINGLE && $stable(strobeMode)) |->
		!upperLaneStoreStrobe_n)
		else $error("byte enable not low");
	single_store_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(state == ext_bus_pkg::ST_STRB && curWrite &&
		strobeMode == ext_bus_pkg::MODE_SINGLE && $stable(strobeMode)) |->
		!lowerLaneStoreStrobe_n)
		else $error("store strobe not low");
	latch_pulse_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(state == ext_bus_pkg::ST_ADDR) |-> addrLatch)
		else $error("address latch missing");
endmodule : ext_bus_ctrl

//--- tb/mem_model.sv
// Far-side memory model for the external bus controller.
// Assumes active-low strobes and a bench-driven stall request.
`timescale 1ns/10ps
module mem_model (
	input wire logic clk_sys,
	input wire logic addrLatch,
	input wire logic [19:0] busAddr,
	input wire logic readStrobe_n,
	input wire logic stall,
	output logic [15:0] busDataIn,
	output logic waitRequest_n
);
	logic [19:0] latched = 20'h0;
	logic [15:0] last = 16'h0;
	always @(posedge clk_sys) begin
		if (addrLatch) begin
			latched <= busAddr;
		end
		if (!readStrobe_n) begin
			last <= busDataIn;
		end
	end
	// Released data lines show the inverse of the last value
	assign busDataIn = !readStrobe_n ? latched[15:0] ^ 16'ha5c3 : ~last;
	assign waitRequest_n = !stall;
endmodule : mem_model

//--- tb/tb.sv
// Self-checking bench for the external bus controller.
// Assumes the bench acts as core and as the requesting bus master.
`timescale 1ns/10ps
module tb;
	logic clk_sys = 1'b0, reset_n = 1'b0, strobeMode = 1'b0, stall = 1'b0;
	logic reqValid = 1'b0, reqWrite = 1'b0, reqWide = 1'b0;
	logic [19:0] reqAddr = 20'h0;
	logic [15:0] reqWdata = 16'h0, rspRdata, busDataIn;
	logic busRequest_n = 1'b1, waitRequest_n, reqReady, rspValid, addrLatch;
	logic [19:0] busAddr;
	logic [15:0] busDataOut, wdat;
	logic busClock, prev;
	localparam int BCLK_EDGES = 40 * ext_bus_pkg::BCLK_HZ / ext_bus_pkg::CLK_HZ;
	logic busAddrOe, busDataOe, strobeOe, busGrantOutput_n, readStrobe_n;
	logic lowerLaneStoreStrobe_n, upperLaneStoreStrobe_n, lo, up, rd, ale;
	int n_mismatch = 0, n_compared = 0, cyc;
	ext_bus_ctrl i_ext_bus_ctrl (.clk_sys(clk_sys), .reset_n(reset_n),
		.strobeMode(strobeMode), .reqValid(reqValid), .reqWrite(reqWrite),
		.reqAddr(reqAddr), .reqWdata(reqWdata), .reqWide(reqWide),
		.reqReady(reqReady), .rspValid(rspValid), .rspRdata(rspRdata),
		.busAddr(busAddr), .busAddrOe(busAddrOe), .busDataIn(busDataIn),
		.busDataOut(busDataOut), .busDataOe(busDataOe),
		.lowerLaneStoreStrobe_n(lowerLaneStoreStrobe_n),
		.upperLaneStoreStrobe_n(upperLaneStoreStrobe_n),
		.readStrobe_n(readStrobe_n), .strobeOe(strobeOe),
		.addrLatch(addrLatch), .busClock(busClock),
		.waitRequest_n(waitRequest_n),
		.busRequest_n(busRequest_n), .busGrantOutput_n(busGrantOutput_n));
	mem_model i_mem_model (.clk_sys(clk_sys), .addrLatch(addrLatch),
		.busAddr(busAddr), .readStrobe_n(readStrobe_n), .stall(stall),
		.busDataIn(busDataIn), .waitRequest_n(waitRequest_n));
	// ==========================================================
	// Shared tasks
	task automatic chk(input string nm, input logic [19:0] s, e);
		n_compared++;
		if (s !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, s);
			n_mismatch++;
		end
	endtask : chk
	task automatic wrap_up;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : wrap_up
	// Runs one access and records which strobes went active
	task automatic acc(input logic w, input logic [19:0] a, input logic wd);
		int k;
		lo = 1'b0;
		up = 1'b0;
		rd = 1'b0;
		ale = 1'b0;
		wdat = 16'h0;
		@(posedge clk_sys);
		reqValid <= 1'b1;
		reqWrite <= w;
		reqAddr <= a;
		reqWide <= wd;
		reqWdata <= a[15:0] ^ 16'h0f0f;
		for (k = 0; k < 200; k++) begin
			@(posedge clk_sys);
			if (reqReady === 1'b1) reqValid <= 1'b0;
			lo |= lowerLaneStoreStrobe_n === 1'b0;
			up |= upperLaneStoreStrobe_n === 1'b0;
			rd |= readStrobe_n === 1'b0;
			ale |= addrLatch === 1'b1;
			if (busDataOe === 1'b1 && (lowerLaneStoreStrobe_n === 1'b0 ||
				upperLaneStoreStrobe_n === 1'b0)) wdat = busDataOut;
			if (rspValid === 1'b1) break;
		end
		cyc = k;
		if (k == 200) begin
			n_mismatch++;
			wrap_up();
		end
	endtask : acc
	// ==========================================================
	// Scenarios
	task automatic t_split;
		strobeMode <= 1'b0;
		acc(1'b1, 20'h00124, 1'b0);
		chk("even lower", {lo, up, rd, ale}, 4'b1001);
		chk("even data", wdat, 16'h0124 ^ 16'h0f0f);
		acc(1'b1, 20'h00125, 1'b0);
		chk("odd upper", {lo, up, rd, ale}, 4'b0101);
		chk("odd data", wdat, 16'h0125 ^ 16'h0f0f);
		acc(1'b1, 20'h00128, 1'b1);
		chk("wide lanes", {lo, up, rd, ale}, 4'b1101);
		chk("wide data", wdat, 16'h0128 ^ 16'h0f0f);
		acc(1'b0, 20'h00346, 1'b1);
		chk("read strobes", {lo, up, rd, ale}, 4'b0011);
		chk("read data", rspRdata, 16'h0346 ^ 16'ha5c3);
		$display("split lanes done");
	endtask : t_split
	task automatic t_single;
		strobeMode <= 1'b1;
		acc(1'b1, 20'h00127, 1'b0);
		chk("odd store", {lo, up, rd}, 3'b110);
		chk("store data", wdat, 16'h0127 ^ 16'h0f0f);
		acc(1'b0, 20'h00126, 1'b0);
		chk("even read", {lo, up, rd}, 3'b001);
		chk("single data", rspRdata, 16'h0126 ^ 16'ha5c3);
		$display("single strobe done");
	endtask : t_single
	task automatic t_wait;
		stall <= 1'b1;
		fork
			acc(1'b0, 20'h00200, 1'b1);
			begin
				repeat (12) @(posedge clk_sys);
				stall <= 1'b0;
			end
		join
		chk("stretched", cyc > 12, 1'b1);
		chk("wait data", rspRdata, 16'h0200 ^ 16'ha5c3);
		$display("wait done");
	endtask : t_wait
	task automatic t_hold;
		int k, g, tog;
		g = 0;
		tog = 0;
		@(posedge clk_sys);
		busRequest_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		prev = busClock;
		for (k = 0; k < 20; k++) begin
			@(posedge clk_sys);
			g += busGrantOutput_n === 1'b0 && strobeOe === 1'b0 &&
				busAddrOe === 1'b0 && busDataOe === 1'b0;
			tog += busClock !== prev;
			prev = busClock;
		end
		chk("hold cycles", g, 20);
		chk("bus clock", tog, BCLK_EDGES);
		busRequest_n <= 1'b1;
		repeat (6) @(posedge clk_sys);
		chk("released", {busGrantOutput_n, strobeOe}, 2'b11);
		acc(1'b1, 20'h00310, 1'b0);
		chk("after hold", lo, 1'b1);
		$display("hold done");
	endtask : t_hold
	// ==========================================================
	// Clock and main sequence
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_split();
		t_single();
		t_wait();
		t_hold();
		wrap_up();
	end
endmodule : tb
